//--- dv/sas_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sas_afe_model (
	input  wire logic       clk,
	input  wire logic       afe_power,
	input  wire logic       afe_sample,
	input  wire logic       afe_ref_ext,
	input  wire logic [1:0] afe_channel,
	input  wire logic [9:0] afe_trial,
	input  wire logic [9:0] vin [4],
	output logic            afe_cmp_hi
);
	logic [9:0] hold_q;
	logic       tog_q = 1'b0;
	always @(posedge clk) begin
		tog_q <= !tog_q;
		if (afe_power && afe_sample)
			hold_q <= afe_ref_ext ? vin[afe_channel] >> 1 : vin[afe_channel];
	end
	// unpowered front end gives a toggling answer; pins only read
	assign afe_cmp_hi = afe_power ? hold_q >= afe_trial : tog_q;
endmodule : sas_afe_model
`default_nettype wire

//--- dv/sas_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sas_chk (
	input wire logic        clk, rst, read, write, waitrequest,
	input wire logic        afe_power, afe_sample, afe_ref_ext,
	input wire logic [9:0]  address,
	input wire logic [31:0] writedata, readdata,
	input wire logic [3:0]  byteenable, pin_analog_en,
	input wire logic [1:0]  afe_channel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire ok = !waitrequest && byteenable[0];
	wire cw = write && ok && address == 10'h07c;
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer after one wait");
	a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
		else $error("wait without request");
	a_chan_follow: assert property (cw |=> afe_channel == $past(writedata[3:2]))
		else $error("channel not routed");
	a_ref_follow: assert property (cw |=> afe_ref_ext == $past(writedata[6]))
		else $error("reference not routed");
	a_off_nopower: assert property (cw && !writedata[0] |=> !afe_power)
		else $error("power with converter off");
	a_pins_follow: assert property (write && ok && address == 10'h27c
		|=> pin_analog_en == $past(writedata[3:0]))
		else $error("pin select not applied");
	a_rsvd_zero: assert property (read && ok && address == 10'h07c |-> readdata[5:4] == 2'h0)
		else $error("reserved bits set");
	a_nopow_nosamp: assert property (!afe_power |-> !afe_sample)
		else $error("sampling while off");
endmodule : sas_chk
bind sas_sar_adc_sequencer sas_chk u_chk (.clk(clk), .rst(rst), .read(read), .write(write),
	.waitrequest(waitrequest), .afe_power(afe_power), .afe_sample(afe_sample),
	.afe_ref_ext(afe_ref_ext), .address(address), .writedata(writedata),
	.readdata(readdata), .byteenable(byteenable), .pin_analog_en(pin_analog_en),
	.afe_channel(afe_channel));
`default_nettype wire

//--- dv/sas_sar_adc_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sas_sar_adc_sequencer_tb;
	import sas_pkg::*;
	localparam int RCD = 4;
	logic        clk = 0, rst = 1, read = 0, write = 0, sleep = 0;
	logic [9:0]  address = '0, trial, v, e;
	logic [31:0] writedata = '0, readdata;
	logic        waitrequest, irq, pwr, smp, refx, cmp;
	logic [1:0]  ch;
	logic [3:0]  pins;
	logic [9:0]  vin [4];
	logic [7:0]  d;
	logic [15:0] f;
	logic [31:0] s;
	int          error_cnt = 0, n_compared = 0, cyc = 0, n, dv;
	always #5 clk = !clk;
	sas_sar_adc_sequencer #(.INSTR_CYCLES(1), .RC_DIV(RCD)) DUT (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest), .sleep(sleep),
		.conv_done_irq(irq), .afe_power(pwr), .afe_channel(ch), .afe_ref_ext(refx),
		.afe_sample(smp), .afe_trial(trial), .afe_cmp_hi(cmp), .pin_analog_en(pins));
	sas_afe_model u_afe (.clk(clk), .afe_power(pwr), .afe_sample(smp), .afe_ref_ext(refx),
		.afe_channel(ch), .afe_trial(trial), .vin(vin), .afe_cmp_hi(cmp));
	task automatic close_out;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] w);
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, w};
		write <= 1'b1;
		do @(posedge clk); while (waitrequest);
		write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [7:0] r);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest);
		r = readdata[7:0];
		read <= 1'b0;
	endtask : rd
	task automatic wait_smp(output int k);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (!smp);
	endtask : wait_smp
	function automatic logic [15:0] fmt(input logic [9:0] r, input logic j);
		return j ? {6'h00, r} : {r, 6'h00};
	endfunction : fmt
	function automatic int fdiv(input logic [2:0] c);
		return (c[1:0] == 2'h3) ? RCD : 1 << (1 + c[2] + 2 * c[0] + 4 * c[1]);
	endfunction : fdiv
	initial begin
		void'($urandom(32'h2b00));
		foreach (vin[i]) vin[i] = 10'h000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(10'h07c, d); chk(d, CTRL_RST);
		rd(10'h27c, d); chk(d, PINCLK_RST);
		chk({4'h0, pins}, 8'h0f);
		rd(10'h100, d); chk(d, 8'h00);
		wr(10'h030, 8'h02);
		wr(10'h07c, 8'h31);
		rd(10'h07c, d); chk(d, 8'h01);
		for (int c = 0; c < 8; c++) begin
			s = $urandom;
			v = (c == 0) ? 10'h3ff : (c == 1) ? 10'h000 : s[13:4];
			vin[s[3:2]] <= v;
			wr(10'h27c, {1'b0, 3'(c), s[17:14]});
			@(posedge clk);
			chk({4'h0, pins}, {4'h0, s[17:14]});
			wr(10'h07c, {s[0], s[1], 2'h0, s[3:2], 2'h1});
			repeat (20) @(posedge clk);
			wr(10'h07c, {s[0], s[1], 2'h0, s[3:2], 2'h3});
			wait_smp(n);
			dv = fdiv(3'(c));
			chk(8'(n >= 11 * dv && n <= 11 * dv + 3), 8'h01);
			rd(10'h07c, d); chk(d, {s[0], s[1], 2'h0, s[3:2], 2'h1});
			chk({7'h00, irq}, 8'h01);
			e = s[1] ? v >> 1 : v;
			f = fmt(e, s[0]);
			rd(10'h078, d); chk(d, f[15:8]);
			rd(10'h278, d); chk(d, f[7:0]);
			wr(10'h030, 8'h03);
			@(posedge clk);
			chk({7'h00, irq}, 8'h00);
		end
		f = fmt(e, 1'b0);
		vin[3] <= ~e;
		wr(10'h27c, 8'h60);
		wr(10'h07c, 8'h0d);
		repeat (20) @(posedge clk);
		wr(10'h07c, 8'h0f);
		rd(10'h07c, d); chk(d, 8'h0f);
		repeat (200) @(posedge clk);
		wr(10'h07c, 8'h0d);
		wait_smp(n);
		chk(8'(n >= 128 && n <= 131), 8'h01);
		rd(10'h07c, d); chk(d, 8'h0d);
		rd(10'h078, d); chk(d, f[15:8]);
		wr(10'h07c, 8'h0f);
		repeat (50) @(posedge clk);
		sleep <= 1'b1;
		repeat (2) @(posedge clk);
		chk({7'h00, pwr}, 8'h00);
		rd(10'h07c, d); chk(d, 8'h0d);
		sleep <= 1'b0;
		wr(10'h07c, 8'h0f);
		repeat (30) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(10'h07c, d); chk(d, 8'h00);
		chk({7'h00, pwr}, 8'h00);
		rd(10'h078, d); chk(d, f[15:8]);
		close_out();
	end
endmodule : sas_sar_adc_sequencer_tb
`default_nettype wire

//--- verilog/sas_pkg.sv
`default_nettype none
package sas_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_RES_HI = 8'h1e;
	localparam logic [7:0] IDX_CTRL   = 8'h1f;
	localparam logic [7:0] IDX_RES_LO = 8'h9e;
	localparam logic [7:0] IDX_PINCLK = 8'h9f;
	localparam logic [7:0] IDX_DONE   = 8'h0c;
	localparam int         ADDR_W     = 10;
	// converter_control fields
	localparam int CTL_JUSTIFY = 7;
	localparam int CTL_REF     = 6;
	localparam int CTL_CHAN    = 2;
	localparam int CTL_GO      = 1;
	localparam int CTL_ON      = 0;
	// analog_pin_and_clock_select fields
	localparam int ANS_CLK     = 4;
	localparam int ANS_PINS    = 0;
	// done register fields
	localparam int DONE_FLAG   = 0;
	localparam int DONE_IE     = 1;
	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] PINCLK_RST = 8'h0f;
	// conversion timing
	localparam int RES_BITS     = 10;
	localparam int CONV_TADS    = 11;
	localparam int ABORT_TADS   = 2;
	localparam int CLK_HZ       = 100_000_000;
	localparam int RC_MAX_KHZ   = 500;
	localparam int RC_CYCLES    = (CLK_HZ / 1000 + RC_MAX_KHZ - 1) / RC_MAX_KHZ;
	localparam int INSTR_CYC    = 4;
	localparam int CNT_W        = 8;
	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_WAIT_INSTR,
		SAS_CONV,
		SAS_HOLDOFF
	} sas_state_t;
endpackage : sas_pkg
`default_nettype wire

//--- verilog/sas_sar_adc_sequencer.sv
// Contract
// - each conversion yields a 10-bit successive-approximation value held in result pair
// - two-bit channel select routes input 0..3 to the sample-and-hold
// - reference bit 1 uses external reference pin, 0 uses supply
// - a full conversion lasts exactly eleven conversion-clock periods
// - clock select decodes /2,/4,/8,/16,/32,/64; codes ending 11 pick internal RC
// - writing go 1 starts conversion; go reads 1 while busy, else 0
// - at end: go clears, done flag sets, interrupt raised when enabled
// - clearing go mid-conversion aborts; result keeps previous completed value
// - after abort wait two conversion-clock periods, then acquisition restarts automatically
// - justify bit 1 gives right-justified result, 0 left-justified
// - converter-on 1 powers the module; 0 shuts it off
// - analog select 1 disables the pin's digital buffer, pull-up, change interrupt
// - hold capacitor is never discharged automatically between conversions
// - internal RC conversion clock runs at 500 kHz at most
// - control register bits 5 and 4 read as zero
// - sleep with non-RC clock aborts conversion, powers off, converter-on stays set
// - with internal RC clock, wait one instruction before conversion starts
// - reset turns converter off, aborts conversion, leaves result unchanged
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sas_sar_adc_sequencer
	import sas_pkg::*;
#(
	parameter int INSTR_CYCLES = INSTR_CYC,
	parameter int RC_DIV       = RC_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// system
	input  wire logic              sleep,
	output logic                   conv_done_irq,
	// analog front end
	output logic                   afe_power,
	output logic      [1:0]        afe_channel,
	output logic                   afe_ref_ext,
	output logic                   afe_sample,
	output logic      [9:0]        afe_trial,
	input  wire logic              afe_cmp_hi,
	// pins
	output logic      [3:0]        pin_analog_en
);

	if (INSTR_CYCLES < 1 || RC_DIV < 2 || RC_DIV > 256 || INSTR_CYCLES > 256) begin : g_chk
		$error("sas_sar_adc_sequencer: counter parameter out of range");
	end

	typedef struct packed {
		sas_state_t       st;
		logic             justify;
		logic             ref_ext;
		logic [1:0]       chan;
		logic             go;
		logic             on;
		logic [2:0]       clk_sel;
		logic [3:0]       ans;
		logic             done_flag;
		logic             done_ie;
		logic             ack;
		logic [7:0]       rdata;
		logic [CNT_W-1:0] div_cnt;
		logic [3:0]       bit_cnt;
		logic [9:0]       trial;
	} sas_regs_t;

	sas_regs_t      r_q;
	sas_regs_t      r_d;
	logic [9:0]     result_q;
	logic [9:0]     result_d;
	logic           result_we;

	// conversion clock reload count: divisor in core cycles minus one
	function automatic logic [CNT_W-1:0] sas_period_cycles(input logic [2:0] sel);
		logic [CNT_W-1:0] n;
		n = CNT_W'(RC_DIV - 1);
		case (sel)
			3'b000:  n = 8'h01;
			3'b100:  n = 8'h03;
			3'b001:  n = 8'h07;
			3'b101:  n = 8'h0f;
			3'b010:  n = 8'h1f;
			3'b110:  n = 8'h3f;
			default: n = CNT_W'(RC_DIV - 1);
		endcase
		return n;
	endfunction : sas_period_cycles

	function automatic logic sas_is_rc(input logic [2:0] sel);
		return sel[1:0] == 2'b11;
	endfunction : sas_is_rc

	// control readback; bits 5:4 unimplemented
	function automatic logic [7:0] sas_ctrl_byte(input sas_regs_t r);
		logic [7:0] b;
		b                = 8'h00;
		b[CTL_JUSTIFY]   = r.justify;
		b[CTL_REF]       = r.ref_ext;
		b[CTL_CHAN +: 2] = r.chan;
		b[CTL_GO]        = r.go;
		b[CTL_ON]        = r.on;
		return b;
	endfunction : sas_ctrl_byte

	// pin and clock select readback; bit 7 unimplemented
	function automatic logic [7:0] sas_pinclk_byte(input sas_regs_t r);
		logic [7:0] b;
		b                = 8'h00;
		b[ANS_CLK +: 3]  = r.clk_sel;
		b[ANS_PINS +: 4] = r.ans;
		return b;
	endfunction : sas_pinclk_byte

	// done flag and enable readback
	function automatic logic [7:0] sas_done_byte(input sas_regs_t r);
		logic [7:0] b;
		b            = 8'h00;
		b[DONE_FLAG] = r.done_flag;
		b[DONE_IE]   = r.done_ie;
		return b;
	endfunction : sas_done_byte

	logic       hit;
	logic [7:0] idx;
	logic       wr_go;
	logic       sleep_off;
	logic       tick;
	logic [3:0] bitpos;
	logic [7:0] res_hi;
	logic [7:0] res_lo;

	assign idx       = address[ADDR_W-1:2];
	assign hit       = (address[1:0] == 2'b00) && byteenable[0];
	assign sleep_off = sleep && !sas_is_rc(r_q.clk_sel);
	assign tick      = (r_q.div_cnt == '0);
	assign bitpos    = 4'(CONV_TADS - 1) - r_q.bit_cnt;
	assign wr_go     = writedata[CTL_GO];

	// result formatting
	always_comb begin
		if (r_q.justify) begin
			res_hi = {6'h00, result_q[9:8]};
			res_lo = result_q[7:0];
		end else begin
			res_hi = result_q[9:2];
			res_lo = {result_q[1:0], 6'h00};
		end
	end

	always_comb begin
		r_d       = r_q;
		result_d  = result_q;
		result_we = 1'b0;
		r_d.ack   = 1'b0;
		// bus answer one cycle after request seen
		if ((read || write) && !r_q.ack) begin
			r_d.ack   = 1'b1;
			r_d.rdata = 8'h00;
			if (hit && read) begin
				case (idx)
					IDX_CTRL:   r_d.rdata = sas_ctrl_byte(r_q);
					IDX_PINCLK: r_d.rdata = sas_pinclk_byte(r_q);
					IDX_RES_HI: r_d.rdata = res_hi;
					IDX_RES_LO: r_d.rdata = res_lo;
					IDX_DONE:   r_d.rdata = sas_done_byte(r_q);
					default:    r_d.rdata = 8'h00;
				endcase
			end
		end

		// conversion clock divider
		if (r_q.st == SAS_CONV || r_q.st == SAS_HOLDOFF) begin
			if (tick) begin
				r_d.div_cnt = sas_period_cycles(r_q.clk_sel);
			end else begin
				r_d.div_cnt = r_q.div_cnt - 1'b1;
			end
		end

		case (r_q.st)
			SAS_IDLE: begin
			end
			SAS_WAIT_INSTR: begin
				if (tick) begin
					r_d.st      = SAS_CONV;
					r_d.bit_cnt = 4'h0;
					r_d.div_cnt = sas_period_cycles(r_q.clk_sel);
				end else begin
					r_d.div_cnt = r_q.div_cnt - 1'b1;
				end
			end
			SAS_CONV: begin
				if (tick) begin
					if (r_q.bit_cnt == 4'h0) begin
						r_d.trial   = 10'h200;
						r_d.bit_cnt = 4'h1;
					end else begin
						r_d.trial[bitpos] = afe_cmp_hi;
						if (bitpos != 4'h0) begin
							r_d.trial[bitpos-1'b1] = 1'b1;
						end
						r_d.bit_cnt = r_q.bit_cnt + 1'b1;
						if (r_q.bit_cnt == 4'(CONV_TADS - 1)) begin
							result_we = 1'b1;
							result_d  = r_d.trial;
							r_d.go    = 1'b0;
							r_d.done_flag = 1'b1;
							r_d.st    = SAS_IDLE;
						end
					end
				end
			end
			SAS_HOLDOFF: begin
				if (tick) begin
					r_d.bit_cnt = r_q.bit_cnt + 1'b1;
					if (r_q.bit_cnt == 4'(ABORT_TADS - 1)) begin
						r_d.st = SAS_IDLE;
					end
				end
			end
			default: r_d.st = SAS_IDLE;
		endcase

		// register writes, taken when waitrequest is low
		if (write && r_q.ack && hit) begin
			case (idx)
				IDX_CTRL: begin
					r_d.justify = writedata[CTL_JUSTIFY];
					r_d.ref_ext = writedata[CTL_REF];
					r_d.chan    = writedata[CTL_CHAN +: 2];
					r_d.on      = writedata[CTL_ON];
					if (r_q.st == SAS_IDLE && wr_go && r_q.on && writedata[CTL_ON]
						&& !sleep_off) begin
						r_d.go    = 1'b1;
						r_d.trial = 10'h000;
						if (sas_is_rc(r_q.clk_sel)) begin
							r_d.st      = SAS_WAIT_INSTR;
							r_d.div_cnt = CNT_W'(INSTR_CYCLES - 1);
						end else begin
							r_d.st      = SAS_CONV;
							r_d.bit_cnt = 4'h0;
							r_d.div_cnt = sas_period_cycles(r_q.clk_sel);
						end
					end else if (r_q.go && !wr_go && r_d.go) begin
						r_d.go      = 1'b0;
						r_d.st      = SAS_HOLDOFF;
						r_d.bit_cnt = 4'h0;
						r_d.div_cnt = sas_period_cycles(r_q.clk_sel);
						result_we   = 1'b0;
					end
				end
				IDX_PINCLK: begin
					r_d.clk_sel = writedata[ANS_CLK +: 3];
					r_d.ans     = writedata[ANS_PINS +: 4];
				end
				IDX_DONE: begin
					r_d.done_ie = writedata[DONE_IE];
					// set wins over a clear in the same cycle
					if (writedata[DONE_FLAG] && !(result_we && r_d.done_flag)) begin
						r_d.done_flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// shutdown or sleep aborts without result
		if (r_q.go && (!r_d.on || sleep_off)) begin
			r_d.go    = 1'b0;
			r_d.st    = SAS_IDLE;
			result_we = 1'b0;
			if (r_q.done_flag == 1'b0) begin
				r_d.done_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_q         <= '0;
			r_q.st      <= SAS_IDLE;
			r_q.justify <= CTRL_RST[CTL_JUSTIFY];
			r_q.ref_ext <= CTRL_RST[CTL_REF];
			r_q.chan    <= CTRL_RST[CTL_CHAN +: 2];
			r_q.go      <= CTRL_RST[CTL_GO];
			r_q.on      <= CTRL_RST[CTL_ON];
			r_q.clk_sel <= PINCLK_RST[ANS_CLK +: 3];
			r_q.ans     <= PINCLK_RST[ANS_PINS +: 4];
		end else begin
			r_q <= r_d;
		end
	end

	// result pair survives reset
	always_ff @(posedge clk) begin
		if (result_we) begin
			result_q <= result_d;
		end
	end

	assign waitrequest   = (read || write) && !r_q.ack;
	assign readdata      = {24'h000000, r_q.rdata};
	assign conv_done_irq = r_q.done_flag && r_q.done_ie;
	assign afe_power     = r_q.on && !sleep_off;
	assign afe_channel   = r_q.chan;
	assign afe_ref_ext   = r_q.ref_ext;
	// acquisition whenever idle and powered; no discharge path
	assign afe_sample    = afe_power && (r_q.st == SAS_IDLE);
	assign afe_trial     = r_q.trial;

	// per-pin analog select; a set bit turns the digital input side off
	for (genvar p = 0; p < 4; p++) begin : g_pin
		assign pin_analog_en[p] = r_q.ans[p];
	end

endmodule : sas_sar_adc_sequencer
`default_nettype wire
